// >>> verilog/bas_pkg.sv
/*
 * shared constants and types for the burst address sequencer:
 * field positions of the configuration word and the command-address phase,
 * wrap group codes and masks, and reset values.
 * assumes nothing of its surroundings.
 */
package bas_pkg;

	// word address width and command-address phase width
	localparam int ADDR_W = 24;
	localparam int CA_W = 48;
	localparam int CFG_W = 16;

	// command-address phase: burst type bit and word address field
	localparam int CA_TYPE_POS = 45;
	localparam int CA_ADDR_LSB = 0;

	// primary configuration register fields
	localparam int CFG_SEQ_POS = 2;
	localparam int CFG_LEN_LSB = 0;
	localparam int CFG_LEN_W = 2;

	// reset values of the configuration fields
	localparam logic CFG_SEQ_RST = 1'h1;
	localparam logic [1:0] CFG_LEN_RST = 2'h3;

	// burst length codes
	localparam logic [1:0] LEN_128 = 2'h0;
	localparam logic [1:0] LEN_64 = 2'h1;
	localparam logic [1:0] LEN_16 = 2'h2;
	localparam logic [1:0] LEN_32 = 2'h3;

	// word masks of the wrap groups (words per group minus one)
	localparam int MASK_W = 6;
	localparam logic [5:0] MASK_128 = 6'h3F;
	localparam logic [5:0] MASK_64 = 6'h1F;
	localparam logic [5:0] MASK_32 = 6'h0F;
	localparam logic [5:0] MASK_16 = 6'h07;

	// address FIFO between sequencer and array side
	localparam int FIFO_DEPTH = 4;

	typedef enum logic {
		ST_IDLE,
		ST_BURST
	} bas_state_t;

endpackage

// >>> verilog/bas_fifo.sv
/*
 * small FIFO with valid and ready on both sides; the head word and its
 * valid sit in flip-flops so that a consumer sees registered outputs.
 * assumes a single clock domain and an active low asynchronous reset.
 */
`timescale 1ns/1ps
module bas_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] data;
		logic [CW-1:0] cnt;
		logic vld;
	} bas_fifo_st_t;

	bas_fifo_st_t st_r;
	bas_fifo_st_t st_nxt;
	logic push;
	logic pop;

	assign in_ready = (st_r.cnt != FULL);
	assign out_valid = st_r.vld;
	assign out_data = st_r.data[0];

	always_comb begin
		st_nxt = st_r;
		pop = st_r.vld && out_ready;
		push = in_valid && in_ready;
		// entries shift toward slot 0 so the head is always a flop
		if (pop) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				st_nxt.data[i] = st_r.data[i + 1];
			end
			st_nxt.cnt = st_r.cnt - CW'(1);
		end
		if (push) begin
			st_nxt.data[st_nxt.cnt] = in_data;
			st_nxt.cnt = st_nxt.cnt + CW'(1);
		end
		st_nxt.vld = (st_nxt.cnt != '0);
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

endmodule // bas_fifo

// >>> verilog/bas_sequencer.sv
/*
 * burst word-address sequencer: captures the start address and burst type
 * at the command-address phase, then emits one word address per rising
 * edge of the bus clock until chip select returns high. linear, legacy
 * wrap and hybrid (one wrap then linear) orders are produced. addresses
 * pass through a 4-word FIFO toward the array side.
 * assumes: bus clock and chip select arrive from pins and are sampled
 * here; command-address and configuration strobes come from logic on clk;
 * the bus clock is slow enough that each level lasts several clk cycles.
 */
`timescale 1ns/1ps
module bas_sequencer (
	input wire logic clk,
	input wire logic resetn,
	input wire logic bus_ck,
	input wire logic bus_cs_n,
	input wire logic ca_valid,
	input wire logic [bas_pkg::CA_W-1:0] command_address_phase,
	input wire logic cfg_wr,
	input wire logic [bas_pkg::CFG_W-1:0] primary_config_register,
	output logic word_valid,
	input wire logic word_ready,
	output logic [bas_pkg::ADDR_W-1:0] word_addr,
	output logic burst_active,
	output logic burst_overrun
);
	import bas_pkg::*;

	typedef struct packed {
		logic [2:0] ck_s;
		logic [2:0] cs_s;
		logic ck_f;
		logic cs_n_f;
		logic cfg_seq;
		logic [CFG_LEN_W-1:0] cfg_len;
		bas_state_t state;
		logic active;
		logic [ADDR_W-1:0] addr;
		logic [ADDR_W-1:0] base;
		logic [MASK_W-1:0] mask;
		logic wrapping;
		logic hybrid;
		logic [MASK_W-1:0] wrap_left;
		logic pending;
		logic overrun;
	} bas_seq_st_t;

	bas_seq_st_t st_r;
	bas_seq_st_t st_nxt;

	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [ADDR_W-1:0] fifo_out_data;

	// wrap mask for a length code
	function automatic logic [MASK_W-1:0] len_mask(input logic [CFG_LEN_W-1:0] len);
		logic [MASK_W-1:0] m;
		m = MASK_32;
		case (len)
			LEN_128: m = MASK_128;
			LEN_64: m = MASK_64;
			LEN_16: m = MASK_16;
			LEN_32: m = MASK_32;
			default: m = MASK_32;
		endcase
		return m;
	endfunction

	bas_fifo #(
		.WIDTH(ADDR_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.resetn(resetn),
		.in_valid(st_r.pending),
		.in_ready(fifo_in_ready),
		.in_data(st_r.addr),
		.out_valid(fifo_out_valid),
		.out_ready(word_ready),
		.out_data(fifo_out_data)
	);

	assign word_valid = fifo_out_valid;
	assign word_addr = fifo_out_data;
	assign burst_active = st_r.active;
	assign burst_overrun = st_r.overrun;

	always_comb begin
		logic ck_rise;
		logic accept;
		logic [MASK_W-1:0] ca_mask;
		logic [ADDR_W-1:0] ca_addr;
		logic [MASK_W-1:0] low_nxt;
		logic [ADDR_W-1:0] group_words;
		ck_rise = 1'b0;
		accept = 1'b0;
		ca_mask = '0;
		ca_addr = '0;
		low_nxt = '0;
		group_words = '0;
		st_nxt = st_r;

		// three-stage pin samplers; a level counts once stages two and three agree
		st_nxt.ck_s = {st_r.ck_s[1:0], bus_ck};
		st_nxt.cs_s = {st_r.cs_s[1:0], bus_cs_n};
		if (st_r.ck_s[1] == st_r.ck_s[2]) begin
			st_nxt.ck_f = st_r.ck_s[2];
		end
		if (st_r.cs_s[1] == st_r.cs_s[2]) begin
			st_nxt.cs_n_f = st_r.cs_s[2];
		end
		ck_rise = st_nxt.ck_f && !st_r.ck_f;

		// configuration is only taken between bursts so a running order never changes
		if (cfg_wr && (st_r.state == ST_IDLE)) begin
			st_nxt.cfg_seq = primary_config_register[CFG_SEQ_POS];
			st_nxt.cfg_len = primary_config_register[CFG_LEN_LSB +: CFG_LEN_W];
		end

		accept = st_r.pending && fifo_in_ready;

		case (st_r.state)
			ST_IDLE: begin
				st_nxt.pending = 1'b0;
			end
			ST_BURST: begin
				if (accept) begin
					st_nxt.pending = 1'b0;
					if (!st_r.wrapping) begin
						st_nxt.addr = st_r.addr + ADDR_W'(1);
					end else begin
						// only the bits under the mask move; the group is left only when a hybrid wrap ends
						low_nxt = (st_r.addr[MASK_W-1:0] + MASK_W'(1)) & st_r.mask;
						st_nxt.addr = {st_r.addr[ADDR_W-1:MASK_W],
							(st_r.addr[MASK_W-1:0] & ~st_r.mask) | low_nxt};
						if (st_r.hybrid) begin
							if (st_r.wrap_left == '0) begin
								group_words = {{(ADDR_W - MASK_W){1'b0}}, st_r.mask} + ADDR_W'(1);
								st_nxt.addr = st_r.base + group_words;
								st_nxt.wrapping = 1'b0;
							end else begin
								st_nxt.wrap_left = st_r.wrap_left - MASK_W'(1);
							end
						end
					end
				end
				// a new beat sets pending even in the cycle the old one leaves
				if (ck_rise) begin
					if (st_r.pending && !accept) begin
						st_nxt.overrun = 1'b1;
					end else begin
						st_nxt.pending = 1'b1;
					end
				end
			end
			default: begin
				st_nxt.state = ST_IDLE;
				st_nxt.active = 1'b0;
				st_nxt.pending = 1'b0;
			end
		endcase

		// start of a transaction: chip select low and a command-address word seen
		if (ca_valid && !st_r.cs_n_f) begin
			ca_addr = command_address_phase[CA_ADDR_LSB +: ADDR_W];
			ca_mask = len_mask(st_nxt.cfg_len);
			st_nxt.state = ST_BURST;
			st_nxt.active = 1'b1;
			st_nxt.addr = ca_addr;
			st_nxt.base = {ca_addr[ADDR_W-1:MASK_W], ca_addr[MASK_W-1:0] & ~ca_mask};
			st_nxt.mask = ca_mask;
			st_nxt.wrapping = !command_address_phase[CA_TYPE_POS];
			st_nxt.hybrid = !command_address_phase[CA_TYPE_POS] && !st_nxt.cfg_seq;
			st_nxt.wrap_left = ca_mask;
			st_nxt.pending = 1'b0;
			st_nxt.overrun = 1'b0;
		end

		// chip select high ends any burst; words already queued still drain
		if (st_r.cs_n_f) begin
			st_nxt.state = ST_IDLE;
			st_nxt.active = 1'b0;
			st_nxt.pending = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_r <= '0;
			st_r.cs_s <= 3'h7;
			st_r.cs_n_f <= 1'b1;
			st_r.cfg_seq <= CFG_SEQ_RST;
			st_r.cfg_len <= CFG_LEN_RST;
			st_r.state <= ST_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

endmodule // bas_sequencer

// >>> tb/bas_seq_assertions.sv
/* port checker for the burst address sequencer.
 assumes bind from the bench, and that a burst drains before the next command. */
`timescale 1ns/1ps
module bas_seq_assertions (
	input wire logic clk,
	input wire logic resetn,
	input wire logic bus_ck,
	input wire logic bus_cs_n,
	input wire logic ca_valid,
	input wire logic [bas_pkg::CA_W-1:0] command_address_phase,
	input wire logic cfg_wr,
	input wire logic [bas_pkg::CFG_W-1:0] primary_config_register,
	input wire logic word_valid,
	input wire logic word_ready,
	input wire logic [bas_pkg::ADDR_W-1:0] word_addr,
	input wire logic burst_active,
	input wire logic burst_overrun
);
	import bas_pkg::*;
	logic [2:0] cfg_q;
	logic [23:0] st_q;
	logic [23:0] prev_q;
	logic lin_q;
	logic seen_q;
	logic [3:0] cs_cnt;
	// cs must have been low long enough to pass the pin filter
	wire ca_ok = ca_valid && !bus_cs_n && cs_cnt > 4'h5;
	wire pop = word_valid && word_ready;
	wire [5:0] m = cfg_q[1:0] == LEN_128 ? MASK_128 : cfg_q[1:0] == LEN_64 ? MASK_64 :
		cfg_q[1:0] == LEN_16 ? MASK_16 : MASK_32;
	wire [23:0] gm = {18'h0, m};
	wire wrap = seen_q && !lin_q;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cfg_q <= {CFG_SEQ_RST, CFG_LEN_RST};
			cs_cnt <= 4'h0;
			st_q <= 24'h0;
			prev_q <= 24'h0;
			lin_q <= 1'b1;
			seen_q <= 1'b0;
		end else begin
			cs_cnt <= bus_cs_n ? 4'h0 : (cs_cnt == 4'hF ? cs_cnt : cs_cnt + 4'h1);
			if (cfg_wr && !burst_active)
				cfg_q <= primary_config_register[2:0];
			if (ca_ok) begin
				st_q <= command_address_phase[23:0];
				lin_q <= command_address_phase[CA_TYPE_POS];
				seen_q <= 1'b0;
			end else if (pop) begin
				prev_q <= word_addr;
				seen_q <= 1'b1;
			end
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	property p_start; ca_ok |=> burst_active && !burst_overrun; endproperty
	a_start: assert property (p_start) else $error("burst not started");
	property p_end; bus_cs_n [*8] |-> !burst_active; endproperty
	a_end: assert property (p_end) else $error("burst outlived chip select");
	property p_hold; word_valid && !word_ready |=> word_valid && $stable(word_addr); endproperty
	a_hold: assert property (p_hold) else $error("word changed while stalled");
	property p_first; pop && !seen_q |-> word_addr == st_q; endproperty
	a_first: assert property (p_first) else $error("first word not start");
	property p_lin; pop && seen_q && lin_q |-> word_addr == prev_q + 24'h1; endproperty
	a_lin: assert property (p_lin) else $error("linear step wrong");
	property p_group; pop && !lin_q && cfg_q[2] |-> (word_addr & ~gm) == (st_q & ~gm); endproperty
	a_group: assert property (p_group) else $error("word left its group");
	property p_step; pop && wrap && cfg_q[2] |-> (word_addr & gm) == ((prev_q + 24'h1) & gm);
	endproperty
	a_step: assert property (p_step) else $error("wrap step wrong");
	property p_hyb; pop && wrap && !cfg_q[2] && (prev_q & ~gm) != (st_q & ~gm)
		|-> word_addr == prev_q + 24'h1; endproperty
	a_hyb: assert property (p_hyb) else $error("hybrid tail not linear");
	c_start: cover property (ca_ok ##1 burst_active);
	c_hyb: cover property (pop && wrap && !cfg_q[2]);
	c_over: cover property ($rose(burst_overrun));
endmodule // bas_seq_assertions

// >>> tb/bas_host_model.sv
/* host side of the bus: chip select, bus clock and command word.
 assumes the bench calls burst() and that clk runs at 50 ns. */
`timescale 1ns/1ps
module bas_host_model (
	input wire logic clk,
	output logic bus_ck,
	output logic bus_cs_n,
	output logic ca_valid,
	output logic [bas_pkg::CA_W-1:0] command_address_phase
);
	import bas_pkg::*;
	initial begin
		bus_ck = 1'b0;
		bus_cs_n = 1'b1;
		ca_valid = 1'b0;
		command_address_phase = 48'h0;
	end
	// bus clock of 8 clk stands still outside frames
	task automatic burst(logic [CA_W-1:0] ca, int n);
		@(posedge clk) bus_cs_n <= 1'b0;
		repeat (6) @(posedge clk);
		command_address_phase <= ca;
		ca_valid <= 1'b1;
		@(posedge clk) ca_valid <= 1'b0;
		command_address_phase <= ~ca;
		repeat (n) begin
			repeat (4) @(posedge clk);
			bus_ck <= 1'b1;
			repeat (4) @(posedge clk);
			bus_ck <= 1'b0;
		end
		repeat (4) @(posedge clk);
		bus_cs_n <= 1'b1; // transfer ends only by raising chip select
		repeat (8) @(posedge clk);
	endtask
endmodule // bas_host_model

// >>> tb/test_burst_address_sequencer.sv
/* self-checking bench: bursts of every order and size against a queue model.
 assumes the host model and checker files are compiled first. */
`timescale 1ns/1ps
module test_burst_address_sequencer;
	import bas_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic cfg_wr = 1'b0;
	logic word_ready = 1'b0;
	logic ready_en = 1'b1;
	logic bus_ck, bus_cs_n, ca_valid, word_valid, burst_active, burst_overrun;
	logic [CA_W-1:0] command_address_phase;
	logic [CFG_W-1:0] primary_config_register = 16'h0;
	logic [ADDR_W-1:0] word_addr;
	logic [31:0] rnd = 32'h00010B4E;
	logic [ADDR_W-1:0] exp_q[$];
	int error_cnt = 0;
	int checks = 0;
	always #25 clk = ~clk;
	bas_host_model host (.clk(clk), .bus_ck(bus_ck), .bus_cs_n(bus_cs_n), .ca_valid(ca_valid),
		.command_address_phase(command_address_phase));
	bas_sequencer dut (.clk(clk), .resetn(resetn), .bus_ck(bus_ck), .bus_cs_n(bus_cs_n),
		.ca_valid(ca_valid), .command_address_phase(command_address_phase), .cfg_wr(cfg_wr),
		.primary_config_register(primary_config_register), .word_valid(word_valid),
		.word_ready(word_ready), .word_addr(word_addr), .burst_active(burst_active),
		.burst_overrun(burst_overrun));
	function automatic logic [31:0] xs(logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	task automatic check(logic [31:0] seen, logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge clk) begin
		rnd <= xs(rnd);
		word_ready <= ready_en & (rnd[0] | rnd[1]);
		if (resetn && word_valid && word_ready && exp_q.size() > 0)
			check(32'(word_addr), 32'(exp_q.pop_front()));
	end
	// keep below n means the consumer stalls, so the buffer fills and beats drop
	task automatic run(bit wr, logic [1:0] len, logic seq, logic typ, logic [23:0] s, int n,
		int keep);
		logic [47:0] ca;
		logic [23:0] gm;
		gm = {18'h0, len == LEN_128 ? MASK_128 : len == LEN_64 ? MASK_64 :
			len == LEN_16 ? MASK_16 : MASK_32};
		ca = {rnd[15:0], rnd};
		ca[CA_TYPE_POS] = typ;
		ca[ADDR_W-1:0] = s;
		for (int i = 0; i < keep; i++)
			exp_q.push_back(ADDR_W'(typ ? s + i : (seq || i <= gm) ?
				(s & ~gm) | ((s + i) & gm) : (s & ~gm) + i));
		ready_en <= (keep == n);
		if (wr) begin
			@(posedge clk) cfg_wr <= 1'b1;
			primary_config_register <= {rnd[15:3], seq, len};
			@(posedge clk) cfg_wr <= 1'b0;
		end
		host.burst(ca, n);
		if (keep < n) begin
			check(32'(burst_overrun), 32'h1);
			check(32'(word_valid), 32'h1);
			ready_en <= 1'b1;
		end
		for (int t = 0; t < 400 && (word_valid || exp_q.size() > 0); t++)
			@(posedge clk);
		check(exp_q.size(), 0);
		if (keep == n)
			check(32'(burst_overrun), 32'h0); // a new command clears the overrun
	endtask
	initial begin
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		repeat (4) @(posedge clk);
		run(0, LEN_32, 1'b1, 1'b0, 24'h00000A, 20, 20);
		run(1, LEN_16, 1'b1, 1'b0, 24'h00000C, 16, 16);
		run(1, LEN_32, 1'b0, 1'b0, 24'h00000A, 20, 20);
		run(1, LEN_64, 1'b0, 1'b0, 24'h00002E, 36, 36);
		run(1, LEN_128, 1'b0, 1'b0, 24'h000003, 68, 68);
		run(1, LEN_16, 1'b0, 1'b1, 24'h00003E, 8, 4);
		run(1, LEN_64, 1'b1, 1'b1, 24'h0000FE, 6, 6);
		wrap_up;
	end
	initial begin
		#2000000;
		error_cnt++;
		wrap_up;
	end
endmodule // test_burst_address_sequencer
bind bas_sequencer bas_seq_assertions u_chk (.clk(clk), .resetn(resetn), .bus_ck(bus_ck),
	.bus_cs_n(bus_cs_n), .ca_valid(ca_valid), .command_address_phase(command_address_phase),
	.cfg_wr(cfg_wr), .primary_config_register(primary_config_register),
	.word_valid(word_valid), .word_ready(word_ready), .word_addr(word_addr),
	.burst_active(burst_active), .burst_overrun(burst_overrun));
